/* File: design/pacer_and_pretrigger_counter.sv */
// pacer divider chain (counters 1, 2) and pre-trigger event counter (counter 0)
// assumes configuration inputs are synchronous to I_CLOCK; pre-trigger pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
module pacer_and_pretrigger_counter (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire pacer_pkg::cnt_cfg_s I_CFG0,
  input wire pacer_pkg::cnt_cfg_s I_CFG1,
  input wire pacer_pkg::cnt_cfg_s I_CFG2,
  input wire logic I_AD_TRIGGER,
  input wire logic I_PRE_TRIGGER,
  input wire logic I_POST_TRIGGER,
  input wire logic I_PRE_TRIGGER_MODE_ENABLE,
  input wire logic I_POST_TRIGGER_MODE_ENABLE,
  input wire logic I_TRIGGER_EVENT_CLEAR,
  output logic O_PACER_TRIGGER,
  output logic [15:0] O_COUNT0,
  output logic [15:0] O_COUNT1,
  output logic [15:0] O_COUNT2,
  output logic O_GATE0,
  output logic O_COUNT0_ZERO,
  output logic O_TRIGGER_EVENT_FLAG
);
  logic [2:0] tb_q, tb_d;
  logic [1:0] pre_sync_q, pre_sync_d, post_sync_q, post_sync_d;
  logic pre_last_q, pre_last_d, post_last_q, post_last_d;
  logic [15:0] div_q [3], div_d [3], cnt_q [3], cnt_d [3];
  pacer_pkg::cnt_mode_e mode_q [3], mode_d [3];
  logic out_q [3], out_d [3];
  logic gate_q, gate_d, flag_q, flag_d, pace_q, pace_d;
  logic tick [3];
  pacer_pkg::cnt_cfg_s cfg [3];
  logic tb_tick, pre_fall, post_rise, cnt0_hit;
  logic [15:0] div1_eff;

  assign cfg[0] = I_CFG0;
  assign cfg[1] = I_CFG1;
  assign cfg[2] = I_CFG2;

  // timebase: one tick in every five clocks makes the 2 MHz count rate
  always_comb
  begin
    tb_d = (tb_q == pacer_pkg::TB_LAST) ? pacer_pkg::TB_CNT_RESET : tb_q + 3'h1;
    tb_tick = (tb_q == pacer_pkg::TB_LAST);
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESET_N)
    begin
      tb_q <= pacer_pkg::TB_CNT_RESET;
    end
    else
    begin
      tb_q <= tb_d;
    end
  end

  // only the second flop of each synchroniser feeds the edge detectors
  always_comb
  begin
    pre_sync_d = {pre_sync_q[0], I_PRE_TRIGGER};
    post_sync_d = {post_sync_q[0], I_POST_TRIGGER};
    pre_last_d = pre_sync_q[1];
    post_last_d = post_sync_q[1];
    pre_fall = pre_last_q & ~pre_sync_q[1] & I_PRE_TRIGGER_MODE_ENABLE;
    post_rise = ~post_last_q & post_sync_q[1] & I_POST_TRIGGER_MODE_ENABLE;
  end

  // the pre-trigger pin idles high; starting its detector high avoids a false fall after reset
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESET_N)
    begin
      pre_sync_q <= 2'h3;
      post_sync_q <= 2'h0;
      pre_last_q <= 1'b1;
      post_last_q <= 1'b0;
    end
    else
    begin
      pre_sync_q <= pre_sync_d;
      post_sync_q <= post_sync_d;
      pre_last_q <= pre_last_d;
      post_last_q <= post_last_d;
    end
  end

  // counter 1 counts the timebase, counter 2 counts counter 1 wraps, counter 0 counts A/D triggers
  assign tick[1] = tb_tick;
  // divisors below two run as two, so counter 2 must compare against the clamped value
  assign div1_eff = (div_q[1] < pacer_pkg::DIV_MIN) ? pacer_pkg::DIV_MIN : div_q[1];
  assign tick[2] = tb_tick & out_q[1] & (cnt_q[1] == div1_eff);
  assign tick[0] = I_AD_TRIGGER & gate_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_cnt
      always_comb
      begin
        div_d[g] = div_q[g];
        mode_d[g] = mode_q[g];
        cnt_d[g] = cnt_q[g];
        out_d[g] = out_q[g];
        if (cfg[g].load)
        begin
          // a count of 0 holds at 0 outside the divider modes; below 2 is clamped to 2 for dividers
          div_d[g] = cfg[g].value;
          mode_d[g] = cfg[g].mode;
          cnt_d[g] = cfg[g].value;
          out_d[g] = (cfg[g].mode != pacer_pkg::MODE_EVENT);
        end
        else if (tick[g])
        begin
          case (mode_q[g])
            pacer_pkg::MODE_EVENT,
            pacer_pkg::MODE_ONESHOT:
            begin
              if (cnt_q[g] != pacer_pkg::COUNT_RESET)
                cnt_d[g] = cnt_q[g] - 16'h0001;
              out_d[g] = (cnt_q[g] == 16'h0001);
            end
            pacer_pkg::MODE_RATE,
            pacer_pkg::MODE_SQUARE:
            begin
              if (cnt_q[g] <= 16'h0001)
                cnt_d[g] = (div_q[g] < pacer_pkg::DIV_MIN) ? pacer_pkg::DIV_MIN : div_q[g];
              else
                cnt_d[g] = cnt_q[g] - 16'h0001;
              if (mode_q[g] == pacer_pkg::MODE_RATE)
                out_d[g] = (cnt_q[g] != 16'h0002);
              else
                out_d[g] = (cnt_q[g] > {1'b0, div_q[g][15:1]}) || (cnt_q[g] <= 16'h0001);
            end
            pacer_pkg::MODE_SW_STROBE,
            pacer_pkg::MODE_HW_STROBE:
            begin
              if (cnt_q[g] != pacer_pkg::COUNT_RESET)
                cnt_d[g] = cnt_q[g] - 16'h0001;
              out_d[g] = (cnt_q[g] != 16'h0001);
            end
            default:
            begin
              cnt_d[g] = cnt_q[g];
            end
          endcase
        end
      end

      always_ff @(posedge I_CLOCK)
      begin
        if (!I_RESET_N)
        begin
          div_q[g] <= pacer_pkg::COUNT_RESET;
          cnt_q[g] <= pacer_pkg::COUNT_RESET;
          mode_q[g] <= pacer_pkg::MODE_EVENT;
          out_q[g] <= 1'b0;
        end
        else
        begin
          div_q[g] <= div_d[g];
          cnt_q[g] <= cnt_d[g];
          mode_q[g] <= mode_d[g];
          out_q[g] <= out_d[g];
        end
      end
    end
  endgenerate

  // counter 0 gate: a fresh load or pre-trigger mode off always closes it
  always_comb
  begin
    cnt0_hit = tick[0] && (cnt_q[0] == 16'h0001);
    gate_d = gate_q;
    if (cfg[0].load || !I_PRE_TRIGGER_MODE_ENABLE)
      gate_d = 1'b0;
    else if (pre_fall)
      gate_d = 1'b1;
    else if (cnt0_hit || cnt_q[0] == pacer_pkg::COUNT_RESET)
      gate_d = 1'b0;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESET_N)
    begin
      gate_q <= 1'b0;
    end
    else
    begin
      gate_q <= gate_d;
    end
  end

  always_comb
  begin
    // set wins over clear so an edge in the clearing cycle is kept
    flag_d = (pre_fall || post_rise) ? 1'b1 : (I_TRIGGER_EVENT_CLEAR ? 1'b0 : flag_q);
    pace_d = tick[2] && (mode_q[2] == pacer_pkg::MODE_EVENT ? 1'b0 : (cnt_q[2] <= 16'h0001));
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESET_N)
    begin
      flag_q <= 1'b0;
      pace_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      pace_q <= pace_d;
    end
  end

  assign O_PACER_TRIGGER = pace_q;
  assign O_COUNT0 = cnt_q[0];
  assign O_COUNT1 = cnt_q[1];
  assign O_COUNT2 = cnt_q[2];
  assign O_GATE0 = gate_q;
  assign O_COUNT0_ZERO = (cnt_q[0] == pacer_pkg::COUNT_RESET);
  assign O_TRIGGER_EVENT_FLAG = flag_q;
endmodule : pacer_and_pretrigger_counter
`default_nettype wire

/* File: design/pacer_pkg.sv */
// constants, modes and carrier structs for the pacer and pre-trigger counter block
// assumes a single 10 MHz clock domain with a synchronous active-low reset
package pacer_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TIMEBASE_HZ = 2000000;
  localparam int unsigned TB_DIV = CLK_HZ / TIMEBASE_HZ;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [2:0] TB_CNT_RESET = 3'h0;
  localparam logic [2:0] TB_LAST = 3'(TB_DIV - 1);

  typedef enum logic [2:0] {
    MODE_EVENT,
    MODE_ONESHOT,
    MODE_RATE,
    MODE_SQUARE,
    MODE_SW_STROBE,
    MODE_HW_STROBE
  } cnt_mode_e;

  typedef struct packed {
    logic load;
    cnt_mode_e mode;
    logic [15:0] value;
  } cnt_cfg_s;
endpackage : pacer_pkg

/* File: verif/ad_trigger_model.sv */
// A/D trigger source: one-cycle pulse every i_gap+1 clocks while enabled
// assumes the bench drives i_en at the falling edge
`timescale 1ns/1ns
`default_nettype none
module ad_trigger_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [7:0] i_gap,
  output logic o_ad_trigger
);
  logic [7:0] cnt_q = 8'h00;
  initial o_ad_trigger = 1'b0;
  // launched on the falling edge so the block samples a settled pulse
  always @(negedge i_clk)
  begin
    cnt_q <= (i_en && cnt_q != i_gap) ? cnt_q + 8'h01 : 8'h00;
    o_ad_trigger <= i_en && cnt_q == i_gap;
  end
endmodule : ad_trigger_model
`default_nettype wire

/* File: verif/pacer_and_pretrigger_counter_bench.sv */
// self-checking bench for the pacer and pre-trigger counter block
// assumes the A/D trigger model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module pacer_and_pretrigger_counter_bench;
  logic clk = 0, rst_n = 0, pre = 1, post = 0, pre_en = 0, post_en = 0, clr = 0, ad_en = 0;
  pacer_pkg::cnt_cfg_s cfg[3] = '{default: '0};
  logic ad, pac, gate, zero, flag;
  logic [15:0] c0, c1, c2;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  pacer_and_pretrigger_counter dut_u (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CFG0(cfg[0]), .I_CFG1(cfg[1]),
    .I_CFG2(cfg[2]), .I_AD_TRIGGER(ad), .I_PRE_TRIGGER(pre), .I_POST_TRIGGER(post),
    .I_PRE_TRIGGER_MODE_ENABLE(pre_en), .I_POST_TRIGGER_MODE_ENABLE(post_en), .I_TRIGGER_EVENT_CLEAR(clr),
    .O_PACER_TRIGGER(pac), .O_COUNT0(c0), .O_COUNT1(c1), .O_COUNT2(c2), .O_GATE0(gate),
    .O_COUNT0_ZERO(zero), .O_TRIGGER_EVENT_FLAG(flag));
  ad_trigger_model pm_u (.i_clk(clk), .i_en(ad_en), .i_gap(8'h07), .o_ad_trigger(ad));
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task ld(input int n, input pacer_pkg::cnt_mode_e md, input logic [15:0] v);
    @(negedge clk) cfg[n] = '{1'b1, md, v};
    @(negedge clk) cfg[n].load = 1'b0;
  endtask : ld
  task t_pacer(input logic [15:0] d1, input logic [15:0] d2);
    int t, e1;
    // a divisor below two runs as two
    e1 = (d1 < pacer_pkg::DIV_MIN) ? pacer_pkg::DIV_MIN : d1;
    ld(1, pacer_pkg::MODE_RATE, d1);
    chk(c1 === d1, "divisor 1 not loaded");
    ld(2, pacer_pkg::MODE_SQUARE, d2);
    chk(c2 === d2, "divisor 2 not loaded");
    // first periods after a reload may be short, so skip them
    repeat (3) @(posedge pac);
    t = cyc;
    @(posedge pac);
    chk(cyc - t == pacer_pkg::TB_DIV * e1 * d2, "pacer period");
  endtask : t_pacer
  task t_mode(input pacer_pkg::cnt_mode_e md);
    ld(1, md, 16'h0003);
    chk(c1 === 16'h0003, "mode load");
    repeat (25) @(negedge clk);
    chk(c1 === 16'h0000, "mode count end");
  endtask : t_mode
  task t_pre;
    ld(0, pacer_pkg::MODE_EVENT, 16'h0003);
    @(negedge clk) pre_en = 1'b1;
    @(negedge clk) pre = 1'b0;
    repeat (6) @(negedge clk);
    chk(gate === 1'b1 && c0 === 16'h0003 && flag === 1'b1, "gate not set");
    ad_en = 1'b1;
    repeat (40) @(negedge clk);
    chk(gate === 1'b0 && c0 === 16'h0000 && zero === 1'b1, "count end");
    ad_en = 1'b0;
    pre = 1'b1;
    pre_en = 1'b0;
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    chk(flag === 1'b0, "flag not cleared");
  endtask : t_pre
  task t_refused;
    ld(0, pacer_pkg::MODE_EVENT, 16'h0005);
    @(negedge clk) pre = 1'b0;
    repeat (6) @(negedge clk);
    chk(gate === 1'b0 && flag === 1'b0 && c0 === 16'h0005, "edge taken with mode off");
    pre = 1'b1;
  endtask : t_refused
  task t_post;
    post_en = 1'b1;
    @(negedge clk) post = 1'b1;
    repeat (6) @(negedge clk);
    chk(flag === 1'b1, "post flag");
  endtask : t_post
  task results;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(gate === 1'b0 && zero === 1'b1 && pac === 1'b0, "reset state");
    t_pacer(16'h0002, 16'h0002);
    t_pacer(16'h0003, 16'h0002);
    t_pacer(16'h0001, 16'h0002);
    t_mode(pacer_pkg::MODE_ONESHOT);
    t_mode(pacer_pkg::MODE_SW_STROBE);
    t_mode(pacer_pkg::MODE_HW_STROBE);
    t_pre();
    t_refused();
    t_post();
    results();
  end
endmodule : pacer_and_pretrigger_counter_bench
`default_nettype wire

/* File: verif/pacer_and_pretrigger_counter_sva.sv */
// port checker for the pacer and pre-trigger counter block
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module pacer_checker (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire pacer_pkg::cnt_cfg_s I_CFG0,
  input wire logic I_AD_TRIGGER,
  input wire logic I_PRE_TRIGGER,
  input wire logic I_PRE_TRIGGER_MODE_ENABLE,
  input wire logic I_POST_TRIGGER_MODE_ENABLE,
  input wire logic I_TRIGGER_EVENT_CLEAR,
  input wire logic O_PACER_TRIGGER,
  input wire logic [15:0] O_COUNT0,
  input wire logic O_GATE0,
  input wire logic O_COUNT0_ZERO,
  input wire logic O_TRIGGER_EVENT_FLAG
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  a_zero_flag: assert property (O_COUNT0_ZERO == (O_COUNT0 == 16'h0000)) else $error("zero flag wrong");
  a_gate_end: assert property (O_GATE0 && I_AD_TRIGGER && O_COUNT0 == 16'h0001 && !I_CFG0.load
    |=> !O_GATE0 && O_COUNT0 == 16'h0000) else $error("gate not cleared at zero");
  a_count_dec: assert property (O_GATE0 && I_AD_TRIGGER && !I_CFG0.load
    |=> O_COUNT0 == $past(O_COUNT0) - 16'h0001) else $error("count not decremented");
  a_count_hold: assert property (!O_GATE0 && !I_CFG0.load |=> $stable(O_COUNT0)) else $error("count moved");
  a_pacer_gap: assert property (O_PACER_TRIGGER |=> !O_PACER_TRIGGER [*4]) else $error("pacer too fast");
  a_gate_rise: assert property ($rose(O_GATE0) |-> $past(I_PRE_TRIGGER_MODE_ENABLE) && !$past(I_PRE_TRIGGER, 3))
    else $error("gate set without falling pin");
  a_gate_mode: assert property (!I_PRE_TRIGGER_MODE_ENABLE |=> !O_GATE0) else $error("gate with mode off");
  a_flag_cause: assert property ($rose(O_TRIGGER_EVENT_FLAG)
    |-> $past(I_PRE_TRIGGER_MODE_ENABLE || I_POST_TRIGGER_MODE_ENABLE)) else $error("flag set unasked");
  a_flag_sticky: assert property (O_TRIGGER_EVENT_FLAG && !I_TRIGGER_EVENT_CLEAR |=> O_TRIGGER_EVENT_FLAG)
    else $error("flag lost");
endmodule : pacer_checker
bind pacer_and_pretrigger_counter pacer_checker chk_u (.*);
`default_nettype wire
